//--- core/tcp_defs.vh
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH

// Register indices; byte address is four times the index
`define TCP_IDX_CHANNEL     8'h03
`define TCP_IDX_CONFIG_ONE  8'h04
`define TCP_IDX_CONFIG_TWO  8'h05
`define TCP_IDX_STATUS      8'h0A
`define TCP_IDX_FREQ        8'h10

`define TCP_RST_CHANNEL     16'h0000
`define TCP_RST_CONFIG_ONE  16'h0000
`define TCP_RST_CONFIG_TWO  16'h0000

// Writable bits; reserved bits are not stored and read as zero
`define TCP_MASK_CHANNEL    16'h83FF
`define TCP_MASK_CONFIG_ONE 16'hDCFF
`define TCP_MASK_CONFIG_TWO 16'h00F0

// Channel register fields
`define TCP_CH_TUNE         15
`define TCP_CH_IDX_HI       9
`define TCP_CH_IDX_LO       0

// Configuration one fields
`define TCP_C1_RDS_IEN      15
`define TCP_C1_DONE_IEN     14
`define TCP_C1_RDS_EN       12
`define TCP_C1_EMPH         11
`define TCP_C1_AGC_OFF      10
`define TCP_C1_BLEND_HI     7
`define TCP_C1_BLEND_LO     6
`define TCP_C1_P3_HI        5
`define TCP_C1_P3_LO        4
`define TCP_C1_P2_HI        3
`define TCP_C1_P2_LO        2
`define TCP_C1_P1_HI        1
`define TCP_C1_P1_LO        0

// Configuration two fields
`define TCP_C2_BAND_HI      7
`define TCP_C2_BAND_LO      6
`define TCP_C2_SPACE_HI     5
`define TCP_C2_SPACE_LO     4

// Status fields
`define TCP_ST_RDS_READY    15
`define TCP_ST_DONE         14
`define TCP_ST_STEREO       8

// Pin modes
`define TCP_PIN_HIZ         2'h0
`define TCP_PIN_FUNC        2'h1
`define TCP_PIN_LOW         2'h2
`define TCP_PIN_HIGH        2'h3

// Band and spacing codes
`define TCP_BAND_WIDE_EU    2'h0
`define TCP_BAND_WIDE_JP    2'h1
`define TCP_BAND_NARROW_JP  2'h2
`define TCP_SPACE_200K      2'h0
`define TCP_SPACE_100K      2'h1
`define TCP_SPACE_50K       2'h2

// Band base frequencies in kHz
`define TCP_BASE_875_KHZ    18'h155CC
`define TCP_BASE_76_KHZ     18'h128E0

// Blend window low ends in dBuV
`define TCP_BLEND_LOW_00    8'h1F
`define TCP_BLEND_LOW_01    8'h25
`define TCP_BLEND_LOW_10    8'h13
`define TCP_BLEND_LOW_11    8'h19

// Timing
`define TCP_CLK_MHZ         250
`define TCP_PULSE_TIME_US   5000
`define TCP_TUNE_CYC        6'h10

`endif

//--- core/tcp_freq_calc.v
`timescale 1ns/10ps
`include "tcp_defs.vh"

module tcp_freq_calc (
  clk,       // System clock
  rstN,      // Synchronised reset, active low
  band,      // Band selection code
  space,     // Channel spacing code
  index,     // Station index
  freqKhz    // Tuned frequency in kHz
);
  input  wire        clk;      // Clock
  input  wire        rstN;     // Reset
  input  wire [1:0]  band;     // Band
  input  wire [1:0]  space;    // Spacing
  input  wire [9:0]  index;    // Index
  output reg  [17:0] freqKhz;  // Frequency

  reg [17:0] stepKhz;
  reg [17:0] baseKhz;
  reg [17:0] freqNxt;
  wire [17:0] idx50 = {8'h00, index} * 18'h00032;

  always @* begin
    case (space)
      `TCP_SPACE_100K: stepKhz = {idx50[16:0], 1'b0};
      `TCP_SPACE_50K:  stepKhz = idx50;
      default:         stepKhz = {idx50[15:0], 2'b00};
    endcase
    // Reserved band 11 uses the low base, as the two Japan bands do
    if (band == `TCP_BAND_WIDE_EU) begin
      baseKhz = `TCP_BASE_875_KHZ;
    end else begin
      baseKhz = `TCP_BASE_76_KHZ;
    end
    freqNxt = baseKhz + stepKhz;
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      freqKhz <= 18'h00000;
    end else begin
      freqKhz <= freqNxt;
    end
  end
endmodule

//--- core/tcp_irq_pulse.v
`timescale 1ns/10ps
`include "tcp_defs.vh"

module tcp_irq_pulse #(
  parameter PULSE_CYC = 1250000
) (
  clk,       // System clock
  rstN,      // Synchronised reset, active low
  trig,      // One-cycle request for a pulse
  active     // High while the low pulse lasts
);
  input  wire clk;     // Clock
  input  wire rstN;    // Reset
  input  wire trig;    // Trigger
  output reg  active;  // Pulse active

  reg [20:0] count_r;
  reg        pending_r;
  wire       lastCyc = (count_r == PULSE_CYC[20:0] - 21'h000001);

  // A trigger during a pulse is held, never restarts or cuts it short
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      active    <= 1'b0;
      count_r   <= 21'h000000;
      pending_r <= 1'b0;
    end else if (active) begin
      if (lastCyc) begin
        active  <= 1'b0;
        count_r <= 21'h000000;
      end else begin
        count_r <= count_r + 21'h000001;
      end
      if (trig) begin
        pending_r <= 1'b1;
      end
    end else if (trig || pending_r) begin
      active    <= 1'b1;
      count_r   <= 21'h000000;
      pending_r <= 1'b0;
    end
  end
endmodule

//--- core/tcp_top.v
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "tcp_defs.vh"

// What this block does
// - Rising edge of the tune request bit starts a tune operation.
// - Finished tune sets the done flag in status bit 14.
// - Band 00 frequency is spacing times index plus 87.5 MHz.
// - Bands 01 and 10 use spacing times index plus 76 MHz.
// - Station index sits in channel bits 9:0 and sets the target.
// - Written index stays; readback follows the tuned channel.
// - Radio data ready event pulses pin two low 5 ms if enabled and the ready flag was clear.
// - Done event pulses pin two low 5 ms if enabled.
// - Pin two: 00 float, 01 interrupt high-rest, 10 low, 11 high.
// - Pin three: 00 float, 01 stereo indicator, 10 low, 11 high.
// - Pin one: 00 float, 10 low, 11 high; 01 reserved.
// - Emphasis select 0 chooses 75 us, 1 chooses 50 us.
// - Gain loop off bit 10 disables automatic gain control.
// - Blend window select picks one of four signal strength windows.
// - Stereo indicator is set above the low end of the window.
// - Channel and configuration registers reset to all zeros.
// - Band code 00 87.5-108, 01 76-108, 10 76-90 MHz; 11 reserved.
// - Spacing code 00 200 kHz, 01 100 kHz, 10 50 kHz.
module tcp_top #(
  parameter PULSE_CYC = `TCP_PULSE_TIME_US * `TCP_CLK_MHZ
) (
  clk,            // System clock, 250 MHz
  rst_n,          // Asynchronous reset, active low
  psel,           // APB select
  penable,        // APB enable
  pwrite,         // APB direction
  paddr,          // APB byte address
  pwdata,         // APB write data
  prdata,         // APB read data
  pready,         // APB ready
  pslverr,        // APB error, unmapped address
  rdsReady,       // Radio data block ready, one cycle
  rssi,           // Measured signal strength in dBuV
  emphasisSelect, // De-emphasis choice, 1 is 50 us
  gainLoopOff,    // Automatic gain control disabled
  radioDataEn,    // Radio data decoder enable
  tuneBusy,       // Tune operation running
  tuneFreqKhz,    // Target frequency in kHz
  pinOneOut,      // Pin one output level
  pinOneOeN,      // Pin one drive enable, active low
  pinTwoOut,      // Pin two output level
  pinTwoOeN,      // Pin two drive enable, active low
  pinThreeOut,    // Pin three output level
  pinThreeOeN     // Pin three drive enable, active low
);
  input  wire        clk;            // Clock
  input  wire        rst_n;          // Reset
  input  wire        psel;           // Select
  input  wire        penable;        // Enable
  input  wire        pwrite;         // Write
  input  wire [7:0]  paddr;          // Address
  input  wire [31:0] pwdata;         // Write data
  output reg  [31:0] prdata;         // Read data
  output reg         pready;         // Ready
  output reg         pslverr;        // Error
  input  wire        rdsReady;       // Data ready event
  input  wire [7:0]  rssi;           // Strength
  output wire        emphasisSelect; // Emphasis
  output wire        gainLoopOff;    // AGC off
  output wire        radioDataEn;    // Data enable
  output wire        tuneBusy;       // Busy
  output wire [17:0] tuneFreqKhz;    // Frequency
  output reg         pinOneOut;      // Pin one level
  output reg         pinOneOeN;      // Pin one enable
  output reg         pinTwoOut;      // Pin two level
  output reg         pinTwoOeN;      // Pin two enable
  output reg         pinThreeOut;    // Pin three level
  output reg         pinThreeOeN;    // Pin three enable

  localparam ST_IDLE   = 3'b001;
  localparam ST_TUNING = 3'b010;
  localparam ST_DONE   = 3'b100;

  reg        rstMeta_r;
  reg        rstSync_r;
  reg [15:0] channel_r;
  reg [15:0] configOne_r;
  reg [15:0] configTwo_r;
  reg [2:0]  state_r;
  reg [5:0]  tuneCnt_r;
  reg        tunePrev_r;
  reg        doneFlag_r;
  reg        doneSeen_r;
  reg        rdsFlag_r;
  reg        rdsSeen_r;
  reg        stereo_r;
  reg [9:0]  readback_r;
  reg        pulseTrig_r;
  reg [31:0] readNxt;
  reg        errNxt;
  wire       pulseActive;

  function [31:0] pad16;
    input [15:0] v;
    begin
      pad16 = {16'h0000, v};
    end
  endfunction

  function decHit;
    input [7:0] addr;
    input [7:0] idx;
    begin
      decHit = (addr[1:0] == 2'b00) && (addr[7:2] == idx[5:0]);
    end
  endfunction

  function [1:0] pinDrive;
    input [1:0] mode;
    input       funcLevel;
    input       funcOk;
    begin
      // Bit 1 is the level, bit 0 the active-low enable
      case (mode)
        `TCP_PIN_LOW:  pinDrive = 2'b00;
        `TCP_PIN_HIGH: pinDrive = 2'b10;
        `TCP_PIN_FUNC: pinDrive = funcOk ? {funcLevel, 1'b0} : 2'b01;
        default:       pinDrive = 2'b01;
      endcase
    end
  endfunction

  // Reset release is synchronised; assertion stays asynchronous
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  wire setupPhase = psel && !penable;
  wire accessDone = psel && penable && pready;
  wire wrDone     = accessDone && pwrite && !pslverr;
  wire rdDone     = accessDone && !pwrite && !pslverr;
  wire hitChan    = decHit(paddr, `TCP_IDX_CHANNEL);
  wire hitCfg1    = decHit(paddr, `TCP_IDX_CONFIG_ONE);
  wire hitCfg2    = decHit(paddr, `TCP_IDX_CONFIG_TWO);
  wire hitStat    = decHit(paddr, `TCP_IDX_STATUS);
  wire hitFreq    = decHit(paddr, `TCP_IDX_FREQ);

  wire [15:0] statusWord = {rdsFlag_r, doneFlag_r, 5'h00,
                            stereo_r, 8'h00} | {6'h00, readback_r};

  always @* begin
    readNxt = 32'h00000000;
    errNxt  = 1'b0;
    if (hitChan) begin
      readNxt = pad16(channel_r);
    end else if (hitCfg1) begin
      readNxt = pad16(configOne_r);
    end else if (hitCfg2) begin
      readNxt = pad16(configTwo_r);
    end else if (hitStat) begin
      readNxt = pad16(statusWord);
    end else if (hitFreq) begin
      readNxt = {14'h0000, tuneFreqKhz};
    end else begin
      errNxt = 1'b1;
    end
  end

  // No wait state: data and answer are registered in the setup cycle
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && errNxt;
      if (setupPhase && !pwrite) begin
        prdata <= readNxt;
      end
    end
  end

  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      channel_r   <= `TCP_RST_CHANNEL;
      configOne_r <= `TCP_RST_CONFIG_ONE;
      configTwo_r <= `TCP_RST_CONFIG_TWO;
    end else if (wrDone) begin
      // Reserved bits are dropped so they always read back zero
      if (hitChan) begin
        channel_r <= pwdata[15:0] & `TCP_MASK_CHANNEL;
      end
      if (hitCfg1) begin
        configOne_r <= pwdata[15:0] & `TCP_MASK_CONFIG_ONE;
      end
      if (hitCfg2) begin
        configTwo_r <= pwdata[15:0] & `TCP_MASK_CONFIG_TWO;
      end
    end
  end

  wire       tuneBit  = channel_r[`TCP_CH_TUNE];
  wire [9:0] stIndex  = channel_r[`TCP_CH_IDX_HI:`TCP_CH_IDX_LO];
  wire       tuneRise = tuneBit && !tunePrev_r;
  wire       tuneEnd  = (state_r == ST_TUNING) &&
                        (tuneCnt_r == `TCP_TUNE_CYC);

  // A new tune needs the previous done flag cleared first
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      state_r    <= ST_IDLE;
      tuneCnt_r  <= 6'h00;
      tunePrev_r <= 1'b0;
      doneFlag_r <= 1'b0;
      readback_r <= 10'h000;
    end else begin
      tunePrev_r <= tuneBit;
      case (state_r)
        ST_IDLE: begin
          if (tuneRise && !doneFlag_r) begin
            state_r   <= ST_TUNING;
            tuneCnt_r <= 6'h00;
          end
        end
        ST_TUNING: begin
          readback_r <= stIndex;
          tuneCnt_r  <= tuneCnt_r + 6'h01;
          if (tuneEnd) begin
            doneFlag_r <= 1'b1;
            state_r    <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (!tuneBit) begin
            doneFlag_r <= 1'b0;
            state_r    <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Clears only after a status read has shown it; a new event wins
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      rdsFlag_r <= 1'b0;
    end else if (rdsReady && configOne_r[`TCP_C1_RDS_EN]) begin
      rdsFlag_r <= 1'b1;
    end else if (rdDone && hitStat && prdata[`TCP_ST_RDS_READY]) begin
      rdsFlag_r <= 1'b0;
    end
  end

  wire doneRise = doneFlag_r && !doneSeen_r;
  wire rdsRise  = rdsFlag_r && !rdsSeen_r;
  wire pinTwoIrq = configOne_r[`TCP_C1_P2_HI:`TCP_C1_P2_LO] == `TCP_PIN_FUNC;
  wire doneEvt   = configOne_r[`TCP_C1_DONE_IEN] && doneRise;
  wire rdsEvt    = configOne_r[`TCP_C1_RDS_IEN] && rdsRise;

  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      doneSeen_r  <= 1'b0;
      rdsSeen_r   <= 1'b0;
      pulseTrig_r <= 1'b0;
    end else begin
      doneSeen_r  <= doneFlag_r;
      rdsSeen_r   <= rdsFlag_r;
      pulseTrig_r <= pinTwoIrq && (doneEvt || rdsEvt);
    end
  end

  tcp_irq_pulse #(
    .PULSE_CYC (PULSE_CYC)
  ) uPulse (
    .clk    (clk),
    .rstN   (rstSync_r),
    .trig   (pulseTrig_r),
    .active (pulseActive)
  );

  tcp_freq_calc uFreq (
    .clk     (clk),
    .rstN    (rstSync_r),
    .band    (configTwo_r[`TCP_C2_BAND_HI:`TCP_C2_BAND_LO]),
    .space   (configTwo_r[`TCP_C2_SPACE_HI:`TCP_C2_SPACE_LO]),
    .index   (stIndex),
    .freqKhz (tuneFreqKhz)
  );

  reg [7:0] blendLow;
  always @* begin
    case (configOne_r[`TCP_C1_BLEND_HI:`TCP_C1_BLEND_LO])
      2'h0:    blendLow = `TCP_BLEND_LOW_00;
      2'h1:    blendLow = `TCP_BLEND_LOW_01;
      2'h2:    blendLow = `TCP_BLEND_LOW_10;
      default: blendLow = `TCP_BLEND_LOW_11;
    endcase
  end

  wire [1:0] drvOne   = pinDrive(configOne_r[`TCP_C1_P1_HI:`TCP_C1_P1_LO],
                                 1'b0, 1'b0);
  wire [1:0] drvTwo   = pinDrive(configOne_r[`TCP_C1_P2_HI:`TCP_C1_P2_LO],
                                 !pulseActive, 1'b1);
  wire [1:0] drvThree = pinDrive(configOne_r[`TCP_C1_P3_HI:`TCP_C1_P3_LO],
                                 stereo_r, 1'b1);

  // Pins float during reset; reserved pin one code also floats
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      stereo_r    <= 1'b0;
      pinOneOut   <= 1'b0;
      pinOneOeN   <= 1'b1;
      pinTwoOut   <= 1'b0;
      pinTwoOeN   <= 1'b1;
      pinThreeOut <= 1'b0;
      pinThreeOeN <= 1'b1;
    end else begin
      stereo_r    <= (rssi > blendLow);
      pinOneOut   <= drvOne[1];
      pinOneOeN   <= drvOne[0];
      pinTwoOut   <= drvTwo[1];
      pinTwoOeN   <= drvTwo[0];
      pinThreeOut <= drvThree[1];
      pinThreeOeN <= drvThree[0];
    end
  end

  assign emphasisSelect = configOne_r[`TCP_C1_EMPH];
  assign gainLoopOff    = configOne_r[`TCP_C1_AGC_OFF];
  assign radioDataEn    = configOne_r[`TCP_C1_RDS_EN];
  assign tuneBusy       = state_r[1];
endmodule

//--- tb/tcp_host.sv
`timescale 1ns/10ps
module tcp_host (
  input  wire        clk,     // Clock
  input  wire        pready,  // Ready
  input  wire [31:0] prdata,  // Read data
  input  wire        pslverr, // Error
  output logic       psel,    // Select
  output logic       penable, // Enable
  output logic       pwrite,  // Direction
  output logic [7:0] paddr,   // Address
  output logic [31:0] pwdata  // Write data
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle limit here; a missing answer is left to the bench watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep the last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

//--- tb/tcp_top_sva.sv
`timescale 1ns/10ps
module tcp_top_sva #(
  parameter PULSE_CYC = 20
) (
  input wire        clk,            // Clock
  input wire        rst_n,          // Reset
  input wire        psel,           // Select
  input wire        penable,        // Enable
  input wire        pwrite,         // Write
  input wire [7:0]  paddr,          // Address
  input wire [31:0] pwdata,         // Data
  input wire        pready,         // Ready
  input wire [7:0]  rssi,           // Strength
  input wire        emphasisSelect, // Emphasis
  input wire        gainLoopOff,    // AGC off
  input wire        radioDataEn,    // Data enable
  input wire        tuneBusy,       // Busy
  input wire [17:0] tuneFreqKhz,    // Frequency
  input wire        pinOneOut,      // Pin one
  input wire        pinOneOeN,      // Pin one enable
  input wire        pinTwoOut,      // Pin two
  input wire        pinTwoOeN,      // Pin two enable
  input wire        pinThreeOut,    // Pin three
  input wire        pinThreeOeN     // Pin three enable
);
  wire        wrEn = psel && penable && pready && pwrite;
  wire        wrCfg = wrEn && paddr == 8'h10;
  wire        wrTune = wrEn && paddr == 8'h0C && pwdata[15];
  wire        wrFreq = wrEn && (paddr == 8'h0C || paddr == 8'h14);
  reg  [15:0] cfg1_r, cfg2_r, chan_r;
  reg  [7:0]  rssi_r, lowCnt_r;
  reg  [5:0]  cfgCnt_r, frCnt_r;
  wire [1:0]  bl = cfg1_r[7:6];
  wire [7:0]  lowEnd = bl == 2'h0 ? 8'h1F : bl == 2'h1 ? 8'h25 :
                       bl == 2'h2 ? 8'h13 : 8'h19;
  wire [17:0] spacing = cfg2_r[5:4] == 2'h1 ? 18'h64 :
                        cfg2_r[5:4] == 2'h2 ? 18'h32 : 18'hC8;
  wire [17:0] expFreq = (cfg2_r[7:6] == 2'h0 ? 18'h155CC : 18'h128E0)
                        + spacing * {8'h00, chan_r[9:0]};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_r <= 16'h0000;
      cfg2_r <= 16'h0000;
      chan_r <= 16'h0000;
      rssi_r <= 8'h00;
      lowCnt_r <= 8'h00;
      cfgCnt_r <= 6'h00;
      frCnt_r <= 6'h00;
    end else begin
      rssi_r <= rssi;
      if (wrCfg) cfg1_r <= pwdata[15:0] & 16'hDCFF;
      if (wrEn && paddr == 8'h14) cfg2_r <= pwdata[15:0] & 16'h00F0;
      if (wrEn && paddr == 8'h0C) chan_r <= pwdata[15:0] & 16'h83FF;
      // Settle counters: pins and frequency lag their inputs
      cfgCnt_r <= (wrCfg || rssi != rssi_r) ? 6'h00 :
                  cfgCnt_r + {5'h00, cfgCnt_r != 6'h3F};
      frCnt_r <= wrFreq ? 6'h00 : frCnt_r + {5'h00, frCnt_r != 6'h3F};
      lowCnt_r <= (pinTwoOut || pinTwoOeN) ? 8'h00 :
                  lowCnt_r + {7'h00, lowCnt_r != 8'hFF};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sPinLow;
    ##[1:6] !pinTwoOut;
  endsequence

  AST_RST: assert property (
    $rose(rst_n) |-> pinOneOeN && pinTwoOeN && pinThreeOeN && !gainLoopOff)
    else $error("outputs not at reset state");
  AST_BUSY: assert property (
    $rose(tuneBusy) |-> $past(wrTune) || $past(wrTune, 2))
    else $error("tune started without request");
  AST_CFG: assert property (
    emphasisSelect == cfg1_r[11] && gainLoopOff == cfg1_r[10] &&
    radioDataEn == cfg1_r[12]) else $error("config outputs differ");
  AST_FREQ: assert property (
    frCnt_r > 6'h04 |-> tuneFreqKhz == expFreq)
    else $error("tuned frequency wrong");
  AST_PIN1: assert property (
    cfgCnt_r > 6'h04 |-> pinOneOeN == !cfg1_r[1] &&
    (pinOneOeN || pinOneOut == cfg1_r[0])) else $error("pin one wrong");
  AST_PIN2: assert property (
    cfgCnt_r > 6'h04 && cfg1_r[3:2] != 2'h1 |->
    pinTwoOeN == (cfg1_r[3:2] == 2'h0) &&
    (pinTwoOeN || pinTwoOut == cfg1_r[2]))
    else $error("pin two wrong");
  AST_PIN3: assert property (
    cfgCnt_r > 6'h04 |-> pinThreeOeN == (cfg1_r[5:4] == 2'h0) && (pinThreeOeN
    || pinThreeOut == (cfg1_r[5:4] == 2'h1 ? rssi > lowEnd : cfg1_r[4])))
    else $error("pin three wrong");
  AST_PLEN: assert property (
    $rose(pinTwoOut) && cfg1_r[3:2] == 2'h1 && lowCnt_r != 8'h00 &&
    {2'h0, cfgCnt_r} > lowCnt_r |-> lowCnt_r == PULSE_CYC)
    else $error("pulse length wrong");
  AST_DONE: assert property (
    $fell(tuneBusy) && cfg1_r[14] && cfg1_r[3:2] == 2'h1 && cfgCnt_r > 6'h04
    && pinTwoOut |-> sPinLow) else $error("no pulse after tune");
endmodule

bind tcp_top tcp_top_sva #(.PULSE_CYC(PULSE_CYC)) u_tcp_top_sva (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .rssi(rssi), .emphasisSelect(emphasisSelect), .gainLoopOff(gainLoopOff),
  .radioDataEn(radioDataEn), .tuneBusy(tuneBusy), .tuneFreqKhz(tuneFreqKhz),
  .pinOneOut(pinOneOut), .pinOneOeN(pinOneOeN), .pinTwoOut(pinTwoOut),
  .pinTwoOeN(pinTwoOeN), .pinThreeOut(pinThreeOut),
  .pinThreeOeN(pinThreeOeN));

//--- tb/tb.sv
`timescale 1ns/10ps
`include "tcp_defs.vh"
`define CHK(a, e) chk((a) === (e))

module tb;
  localparam int   PULSE = 20;
  localparam [7:0] A_CH = 8'(`TCP_IDX_CHANNEL * 4);
  localparam [7:0] A_C1 = 8'(`TCP_IDX_CONFIG_ONE * 4);
  localparam [7:0] A_C2 = 8'(`TCP_IDX_CONFIG_TWO * 4);
  localparam [7:0] A_ST = 8'(`TCP_IDX_STATUS * 4);
  localparam [7:0] A_FR = 8'(`TCP_IDX_FREQ * 4);
  logic        clk, rst_n, rdsReady, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  rssi, paddr;
  logic [31:0] pwdata, prdata, q;
  logic        emphasisSelect, gainLoopOff, radioDataEn, tuneBusy;
  logic [17:0] tuneFreqKhz;
  logic        pinOneOut, pinOneOeN, pinTwoOut, pinTwoOeN;
  logic        pinThreeOut, pinThreeOeN;
  int          nErrors, nChecks, seed, n, len, mC1, idx, expF, lo;

  tcp_top #(.PULSE_CYC(PULSE)) u_tcp_top (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rdsReady(rdsReady), .rssi(rssi),
    .emphasisSelect(emphasisSelect), .gainLoopOff(gainLoopOff),
    .radioDataEn(radioDataEn), .tuneBusy(tuneBusy),
    .tuneFreqKhz(tuneFreqKhz), .pinOneOut(pinOneOut),
    .pinOneOeN(pinOneOeN), .pinTwoOut(pinTwoOut), .pinTwoOeN(pinTwoOeN),
    .pinThreeOut(pinThreeOut), .pinThreeOeN(pinThreeOeN));
  tcp_host u_host (
    .clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input bit ok);
    nChecks++;
    if (!ok) begin
      nErrors++;
      $display("BAD t=%0t value differs from model", $time);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(a, 1'b1, d, q, e);
  endtask

  task rd(input logic [7:0] a);
    u_host.xfer(a, 1'b0, 32'h0, q, e);
  endtask

  task pinExp(input [1:0] m, input ok, input lvl, input oeN, input out);
    `CHK(oeN, m == 2'h0 || (m == 2'h1 && !ok));
    if (oeN === 1'b0) `CHK(out, m == 2'h1 ? lvl : m[0]);
  endtask

  // Low cycles of the next pin two pulse; zero if none starts in time
  task plen(output int len);
    int w;
    len = 0;
    for (w = 0; w < 40 && pinTwoOut; w++) @(posedge clk);
    while (!pinTwoOut && len < 100) begin
      @(posedge clk);
      len++;
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    nErrors++;
    close_out;
  end

  initial begin
    seed = 52;
    nErrors = 0;
    nChecks = 0;
    rst_n = 1'b0;
    rdsReady = 1'b0;
    rssi = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (n = 0; n < 3; n++) begin
      rd(A_CH + 8'(4 * n));
      `CHK(q, 32'h0);
    end
    rd(8'h20);
    `CHK(e, 1'b1);
    $display("test reset done");
    for (n = 0; n < 8; n++) begin
      // Reserved bits kept zero; every pin mode code visited
      mC1 = ($random(seed) & 32'hDCC0) | (n % 4) * 32'h15;
      rssi <= 8'($random(seed));
      wr(A_C1, mC1);
      rd(A_C1);
      `CHK(q, 32'(mC1));
      repeat (5) @(posedge clk);
      `CHK(emphasisSelect, mC1[11]);
      `CHK(gainLoopOff, mC1[10]);
      lo = mC1[7:6] == 0 ? 31 : mC1[7:6] == 1 ? 37 : mC1[7:6] == 2 ? 19 : 25;
      pinExp(mC1[1:0], 1'b0, 1'b0, pinOneOeN, pinOneOut);
      pinExp(mC1[3:2], 1'b1, 1'b1, pinTwoOeN, pinTwoOut);
      pinExp(mC1[5:4], 1'b1, rssi > lo, pinThreeOeN, pinThreeOut);
    end
    $display("test config done");
    for (n = 0; n < 9; n++) begin
      idx = $random(seed) & 32'hFF;
      wr(A_C2, (n / 3) * 32'h40 + (n % 3) * 32'h10);
      wr(A_CH, idx);
      expF = (n < 3 ? 87500 : 76000)
             + (n % 3 == 0 ? 200 : n % 3 == 1 ? 100 : 50) * idx;
      repeat (3) @(posedge clk);
      `CHK(tuneFreqKhz, 18'(expF));
      rd(A_FR);
      `CHK(q, 32'(expF));
      rd(A_CH);
      `CHK(q, 32'(idx));
    end
    $display("test frequency done");
    wr(A_C1, 32'h4004);
    for (n = 0; n < 2; n++) begin
      idx = 5 + n * 600;
      wr(A_CH, 32'h8000 | idx);
      plen(len);
      `CHK(len, PULSE);
      rd(A_ST);
      `CHK(q[14], 1'b1);
      `CHK(q[9:0], 10'(idx));
      wr(A_CH, 32'h8000 | idx);
      repeat (3) @(posedge clk);
      `CHK(tuneBusy, 1'b0);
      wr(A_CH, idx);
      repeat (2) @(posedge clk);
      rd(A_ST);
      `CHK(q[14], 1'b0);
    end
    $display("test tune done");
    wr(A_C1, 32'h9004);
    for (n = 0; n < 3; n++) begin
      @(posedge clk);
      rdsReady <= 1'b1;
      @(posedge clk);
      rdsReady <= 1'b0;
      plen(len);
      `CHK(len, n == 1 ? 0 : PULSE);
      if (n == 1) begin
        rd(A_ST);
        `CHK(q[15], 1'b1);
        rd(A_ST);
        `CHK(q[15], 1'b0);
      end
    end
    $display("test radio data done");
    close_out;
  end
endmodule
